// file: design/cucc_chains.sv
// configuration and error-capture chains of the cache and bus unit
`timescale 1ns/1ps
`include "cucc_map.svh"
// Behaviour
// RL1: boot chain has 367 positions; only the low 303 carry configuration.
// RL2: after self-test in reset, shift exactly 367 boot bits, msb first.
// RL3: run-time chain is 36 bits, six bits shifted in per write.
// RL4: error chain is 60 bits; each strobe write moves six bits out.
// RL5: data port write holds six bits, shifted in when instruction retires.
// RL6: after a strobe write, data port read returns six bits moved out.
// RL7: writing one to strobe bit 0 moves six error bits into data port.
// RL8: boot contents must program duplicate fields equal to their originals.
// RL9: fields ordered lsb first; multibit field lsb at earliest position.
// RL10: position 0 enables wide 32-byte io transfer mode.
// RL11: positions 1 and 2 hold offset fill mode and its duplicate.
// RL12: eight-bit decoded victim stream threshold, at most six victims.
// RL13: one bit enables sending clean evicted blocks to system interface.
// RL14: two-bit system address width select, then one bus format bit.
// RL15: one-hot clock ratio: 0001 1.5x, 0010 2x, 0100 2.5x, 1000 3x.
// RL16: bit after clock ratio enables shadow tag mode.
// RL17: boot configuration outputs held inactive until full load completes.
module cucc_chains
   import cucc_pkg::*;
#(
   parameter int BOOT_LEN = `CUCC_BOOT_LEN,
   parameter int RUN_LEN  = `CUCC_RUN_LEN,
   parameter int ERR_LEN  = `CUCC_ERR_LEN
) (
   input  wire logic                 clock_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 hw_reset_in,
   input  wire logic                 selftest_done_in,
   input  wire logic                 serial_boot_rom_data_in,
   output logic                      serial_boot_rom_clk_out,
   input  wire logic                 priv_reg_write_in,
   input  wire logic                 write_retire_in,
   input  wire logic                 sel_data_port_in,
   input  wire logic                 sel_shift_strobe_in,
   input  wire logic [63:0]          wdata_in,
   input  wire logic                 priv_reg_read_in,
   output logic      [63:0]          rdata_out,
   input  wire logic                 err_capture_in,
   input  wire logic [ERR_LEN-1:0]   err_value_in,
   output logic      [RUN_LEN-1:0]   run_config_out,
   output logic                      boot_done_out,
   output logic                      wide_io_en_out,
   output logic                      offset_fill_mode_out,
   output logic      [7:0]           victim_stream_threshold_out,
   output logic                      clean_evict_en_out,
   output logic      [1:0]           sysbus_width_sel_out,
   output logic                      sysbus_format_sel_out,
   output logic      [3:0]           sysclk_ratio_sel_out,
   output logic                      shadow_tag_en_out
);
   typedef struct packed {
      cucc_boot_type       st;
      logic [8:0]          cnt;
      logic [8:0]          pulses;
      logic [BOOT_LEN-1:0] chain;
      logic [2:0]          rom_sync;
      logic [3:0]          tap;
      logic                rom_bit;
      logic                clk;
      logic [5:0]          hold;
      logic                hold_valid;
      logic [5:0]          port;
      logic                strobe;
   } cucc_state_type;

   cucc_state_type s_q, s_d;
   logic [RUN_LEN-1:0] run_chain;
   logic [ERR_LEN-1:0] err_chain;
   logic [5:0]         err_spill;
   logic               run_shift;

   function automatic logic wr_hit(input logic sel);
      return priv_reg_write_in && sel;
   endfunction : wr_hit

   // only the port sync stages two and three are compared; stage one feeds
   // stage two alone
   always_comb begin
      s_d = s_q;
      s_d.rom_sync = {s_q.rom_sync[1:0], serial_boot_rom_data_in};
      if (s_q.rom_sync[2] == s_q.rom_sync[1]) begin
         s_d.rom_bit = s_q.rom_sync[2];
      end
      // delayed copies of the rom clock; the fourth marks a settled bit
      s_d.tap    = {s_q.tap[2:0], s_q.clk};
      s_d.strobe = 1'b0;
      unique case (s_q.st)
         CUCC_WAIT: begin
            if (hw_reset_in && selftest_done_in) begin // RL2
               s_d.st     = CUCC_LOAD;
               s_d.cnt    = '0;
               s_d.pulses = '0;
               s_d.clk    = 1'b0;
            end
         end
         CUCC_LOAD: begin
            // one pulse per two clocks, stopped after one per position
            if (s_q.pulses != 9'(BOOT_LEN)) begin // RL2
               s_d.clk = ~s_q.clk;
               if (s_q.clk) begin
                  s_d.pulses = s_q.pulses + 9'd1;
               end
            end
            // taking a bit four clocks after its pulse covers the rom's
            // output change and the pin synchroniser; costs four clocks
            if (s_q.tap[3]) begin
               // msb first enters at position 0 and walks toward the top
               s_d.chain = {s_q.chain[BOOT_LEN-2:0], s_q.rom_bit}; // RL2
               s_d.cnt   = s_q.cnt + 9'd1;
               if (s_q.cnt == 9'(BOOT_LEN - 1)) begin // RL1
                  s_d.st = CUCC_DONE;
               end
            end
         end
         CUCC_DONE: begin
            s_d.clk = 1'b0;
         end
         default: begin
            s_d.st  = CUCC_WAIT;
            s_d.clk = 1'b0;
         end
      endcase
      if (wr_hit(sel_data_port_in)) begin
         s_d.hold       = wdata_in[`CUCC_DATA_LSB +: `CUCC_GROUP]; // RL5
         s_d.hold_valid = 1'b1;
      end else if (write_retire_in && s_q.hold_valid) begin
         s_d.hold_valid = 1'b0;
      end
      if (wr_hit(sel_shift_strobe_in) && wdata_in[`CUCC_STROBE_BIT]) begin
         s_d.strobe = 1'b1; // RL7
      end
      if (s_q.strobe) begin
         s_d.port = err_spill; // RL6
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // shift at retirement, never at the write itself
   assign run_shift = write_retire_in && s_q.hold_valid; // RL5

   cucc_shift #(.LEN(RUN_LEN), .STEP(`CUCC_GROUP)) u_run ( // RL3
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .shift_in    (run_shift),
      .data_in     (s_q.hold),
      .load_in     (1'b0),
      .load_val_in ('0),
      .chain_out   (run_chain),
      .spill_out   ()
   );

   // capture wins over a shift in the same cycle; error bits are not lost
   cucc_shift #(.LEN(ERR_LEN), .STEP(`CUCC_GROUP)) u_err ( // RL4
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .shift_in    (s_d.strobe),
      .data_in     ('0),
      .load_in     (err_capture_in),
      .load_val_in (err_value_in),
      .chain_out   (err_chain),
      .spill_out   (err_spill)
   );

   assign serial_boot_rom_clk_out = s_q.clk;
   assign run_config_out          = run_chain;
   assign rdata_out   = {58'h0, s_q.port}; // RL6
   assign boot_done_out = (s_q.st == CUCC_DONE);

   // fields only go live after the full load
   always_comb begin
      wide_io_en_out = 1'b0;
      offset_fill_mode_out = 1'b0;
      victim_stream_threshold_out = 8'h0;
      clean_evict_en_out = 1'b0;
      sysbus_width_sel_out = 2'h0;
      sysbus_format_sel_out = 1'b0;
      sysclk_ratio_sel_out = 4'h0;
      shadow_tag_en_out = 1'b0;
      if (boot_done_out) begin // RL17
         wide_io_en_out = s_q.chain[`CUCC_POS_WIDE_IO]; // RL10
         // duplicate assumed equal to original; original is used
         offset_fill_mode_out = s_q.chain[`CUCC_POS_FILL]; // RL11 RL8
         victim_stream_threshold_out =
            s_q.chain[`CUCC_POS_VICTIM +: 8]; // RL12 RL9
         clean_evict_en_out = s_q.chain[`CUCC_POS_CLEAN]; // RL13
         sysbus_width_sel_out = s_q.chain[`CUCC_POS_BUSW +: 2]; // RL14
         sysbus_format_sel_out = s_q.chain[`CUCC_POS_BUSF]; // RL14
         sysclk_ratio_sel_out = s_q.chain[`CUCC_POS_RATIO +: 4]; // RL15
         shadow_tag_en_out = s_q.chain[`CUCC_POS_SHADOW]; // RL16
      end
   end

   logic unused_ok;
   assign unused_ok = priv_reg_read_in;

   sequence boot_step_s;
      s_q.st == CUCC_LOAD && s_q.tap[3];
   endsequence : boot_step_s

   sequence strobe_take_s;
      wr_hit(sel_shift_strobe_in) && wdata_in[`CUCC_STROBE_BIT]
         && !err_capture_in;
   endsequence : strobe_take_s

   boot_len_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      (s_q.st == CUCC_LOAD && s_d.st == CUCC_DONE) |-> s_q.cnt == 9'd366)
      else $error("boot load ended at wrong count");
   boot_gate_a: assert property (@(posedge clock_in) // RL17
      disable iff (!rst_n_in)
      !boot_done_out |-> !shadow_tag_en_out && sysclk_ratio_sel_out == 4'h0)
      else $error("boot field live before load done");
   boot_wait_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      (s_q.st == CUCC_WAIT && !(hw_reset_in && selftest_done_in))
         |=> s_q.st == CUCC_WAIT)
      else $error("boot load started without self-test done");
   boot_start_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      (s_q.st == CUCC_WAIT && hw_reset_in && selftest_done_in)
         |=> s_q.st == CUCC_LOAD && s_q.cnt == 9'd0 && s_q.pulses == 9'd0)
      else $error("boot load did not start clean");
   rom_clk_idle_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      s_q.st != CUCC_LOAD |-> !serial_boot_rom_clk_out)
      else $error("rom clock running outside a load");
   pulse_cap_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      s_q.pulses <= 9'(BOOT_LEN))
      else $error("rom clock gave too many pulses");
   rom_half_rate_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      serial_boot_rom_clk_out |=> !serial_boot_rom_clk_out)
      else $error("rom clock high for two cycles");
   boot_shift_a: assert property (@(posedge clock_in) // RL2
      disable iff (!rst_n_in)
      boot_step_s |=> s_q.chain[0] == $past(s_q.rom_bit)
         && s_q.chain[BOOT_LEN-1:1] == $past(s_q.chain[BOOT_LEN-2:0]))
      else $error("boot chain did not take the rom bit");
   boot_done_hold_a: assert property (@(posedge clock_in) // RL17
      disable iff (!rst_n_in)
      boot_done_out |=> boot_done_out)
      else $error("boot done dropped without reset");

   hold_set_a: assert property (@(posedge clock_in) // RL5
      disable iff (!rst_n_in)
      wr_hit(sel_data_port_in)
         |=> s_q.hold_valid && s_q.hold == $past(wdata_in[5:0]))
      else $error("data port write not held");
   hold_clear_a: assert property (@(posedge clock_in) // RL5
      disable iff (!rst_n_in)
      (run_shift && !wr_hit(sel_data_port_in)) |=> !s_q.hold_valid)
      else $error("held bits still pending after retire");
   retire_shift_a: assert property (@(posedge clock_in) // RL5
      disable iff (!rst_n_in)
      run_shift |=> run_chain[5:0] == $past(s_q.hold))
      else $error("run chain did not take held bits");
   run_shift_a: assert property (@(posedge clock_in) // RL3
      disable iff (!rst_n_in)
      run_shift |=> run_chain[RUN_LEN-1:6] == $past(run_chain[RUN_LEN-7:0]))
      else $error("run chain did not move up six bits");
   run_still_a: assert property (@(posedge clock_in) // RL3
      disable iff (!rst_n_in)
      !run_shift |=> $stable(run_chain))
      else $error("run chain moved without a retire");

   strobe_port_a: assert property (@(posedge clock_in) // RL6
      disable iff (!rst_n_in)
      strobe_take_s
         |=> ##1 rdata_out[5:0] == $past(err_chain[ERR_LEN-1 -: 6], 2))
      else $error("port missed shifted error bits");
   strobe_zero_a: assert property (@(posedge clock_in) // RL7
      disable iff (!rst_n_in)
      !(wr_hit(sel_shift_strobe_in) && wdata_in[`CUCC_STROBE_BIT])
         |=> !s_q.strobe)
      else $error("strobe fired without a one in bit zero");
   rdata_hi_a: assert property (@(posedge clock_in) // RL6
      disable iff (!rst_n_in)
      rdata_out[63:6] == '0)
      else $error("reserved port bits nonzero");
   err_capture_a: assert property (@(posedge clock_in) // RL4
      disable iff (!rst_n_in)
      err_capture_in |=> err_chain == $past(err_value_in))
      else $error("error chain missed a capture");
   err_shift_a: assert property (@(posedge clock_in) // RL4
      disable iff (!rst_n_in)
      (s_d.strobe && !err_capture_in)
         |=> err_chain == {$past(err_chain[ERR_LEN-7:0]), 6'h00})
      else $error("error chain did not shift six bits out");
   err_still_a: assert property (@(posedge clock_in) // RL4
      disable iff (!rst_n_in)
      (!s_d.strobe && !err_capture_in) |=> $stable(err_chain))
      else $error("error chain moved without strobe or capture");
   port_still_a: assert property (@(posedge clock_in) // RL6
      disable iff (!rst_n_in)
      !s_q.strobe |=> $stable(rdata_out))
      else $error("port data changed without a strobe");
endmodule : cucc_chains

// file: shared/cucc_map.svh
// constants for the cache unit configuration chains
`ifndef CUCC_MAP_SVH
`define CUCC_MAP_SVH
`define CUCC_BOOT_LEN        367
`define CUCC_BOOT_USED       303
`define CUCC_RUN_LEN         36
`define CUCC_ERR_LEN         60
`define CUCC_GROUP           6
`define CUCC_DATA_LSB        0
`define CUCC_STROBE_BIT      0
`define CUCC_POS_WIDE_IO     0
`define CUCC_POS_FILL        1
`define CUCC_POS_FILL_DUP    2
`define CUCC_POS_VICTIM      3
`define CUCC_POS_CLEAN       11
`define CUCC_POS_BUSW        12
`define CUCC_POS_BUSF        14
`define CUCC_POS_RATIO       15
`define CUCC_POS_SHADOW      19
`define CUCC_RATIO_1P5       4'h1
`define CUCC_RATIO_2P0       4'h2
`define CUCC_RATIO_2P5       4'h4
`define CUCC_RATIO_3P0       4'h8
`endif

// file: shared/cucc_pkg.sv
// types for the cache unit configuration chains
package cucc_pkg;
   typedef enum logic [1:0] {
      CUCC_WAIT = 2'b00,
      CUCC_LOAD = 2'b01,
      CUCC_DONE = 2'b11
   } cucc_boot_type;
endpackage : cucc_pkg

// file: design/cucc_shift.sv
// generic serial shift chain, shifts in at bit 0 toward the top
`timescale 1ns/1ps
module cucc_shift #(
   parameter int LEN  = 36,
   parameter int STEP = 6
) (
   input  wire logic            clock_in,
   input  wire logic            rst_n_in,
   input  wire logic            shift_in,
   input  wire logic [STEP-1:0] data_in,
   input  wire logic            load_in,
   input  wire logic [LEN-1:0]  load_val_in,
   output logic      [LEN-1:0]  chain_out,
   output logic      [STEP-1:0] spill_out
);
   logic [LEN-1:0]  chain_q;
   logic [STEP-1:0] spill_q;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         chain_q <= '0;
         spill_q <= '0;
      end else if (load_in) begin
         chain_q <= load_val_in;
      end else if (shift_in) begin
         chain_q <= {chain_q[LEN-STEP-1:0], data_in};
         spill_q <= chain_q[LEN-1 -: STEP];
      end
   end
   assign chain_out = chain_q;
   assign spill_out = spill_q;
endmodule : cucc_shift

// file: verification/cucc_rom_model.sv
// serial boot rom model that feeds the boot chain msb first
`timescale 1ns/1ps
module cucc_rom_model #(
   parameter int LEN = 367
) (
   input  wire logic           clock_in,
   input  wire logic           rst_n_in,
   input  wire logic           rom_clk_in,
   input  wire logic [LEN-1:0] image_in,
   output logic                rom_data_out
);
   int   idx_q = LEN - 1;
   logic clk_q = 1'b0;
   // advance after the falling rom clock so the pin is steady while sampled
   always @(posedge clock_in) begin
      clk_q <= rom_clk_in;
      // every chip reset restarts the image from its top bit
      if (!rst_n_in) begin
         idx_q <= LEN - 1;
      end else if (clk_q && !rom_clk_in && idx_q >= 0) begin
         idx_q <= idx_q - 1;
      end
   end
   // past the last bit the line is driven with clk_q, the delayed rom clock, not an image bit
   assign rom_data_out = (idx_q >= 0) ? image_in[idx_q] : clk_q;
endmodule : cucc_rom_model

// file: verification/tb_cucc_chains.sv
// self-checking bench for the configuration chains
`timescale 1ns/1ps
module tb_cucc_chains;
   import cucc_pkg::*;
   logic         clock_in = 1'b0, rst_n_in = 1'b0, hw_rst = 1'b1;
   logic         st_done = 1'b0, wr = 1'b0, ret = 1'b0, rd = 1'b0;
   logic         sel_dp = 1'b0, sel_ss = 1'b0, cap = 1'b0;
   logic         rom_data, rom_clk, done, wide, fill, clean, fmt, shadow;
   logic [63:0]  wdata = '0, rdata;
   logic [59:0]  err = '0, exp_err;
   logic [35:0]  run_cfg, exp_run;
   logic [7:0]   thr;
   logic [1:0]   busw;
   logic [3:0]   ratio;
   logic [366:0] img = '0;
   logic [31:0]  seed = 32'h96ea44ee;
   int           n_fail = 0, checks = 0, n, hi;

   cucc_chains u_cucc_chains (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .hw_reset_in(hw_rst), .selftest_done_in(st_done),
      .serial_boot_rom_data_in(rom_data), .serial_boot_rom_clk_out(rom_clk),
      .priv_reg_write_in(wr), .write_retire_in(ret),
      .sel_data_port_in(sel_dp), .sel_shift_strobe_in(sel_ss),
      .wdata_in(wdata), .priv_reg_read_in(rd), .rdata_out(rdata),
      .err_capture_in(cap), .err_value_in(err), .run_config_out(run_cfg),
      .boot_done_out(done), .wide_io_en_out(wide),
      .offset_fill_mode_out(fill), .victim_stream_threshold_out(thr),
      .clean_evict_en_out(clean), .sysbus_width_sel_out(busw),
      .sysbus_format_sel_out(fmt), .sysclk_ratio_sel_out(ratio),
      .shadow_tag_en_out(shadow));
   cucc_rom_model u_cucc_rom_model (.clock_in(clock_in), .rom_clk_in(rom_clk),
      .rst_n_in(rst_n_in), .image_in(img), .rom_data_out(rom_data));

   initial begin
      forever #20 clock_in = ~clock_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic cmp(input string nm, input logic [63:0] e,
                      input logic [63:0] g);
      checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : cmp

   task automatic wr_reg(input logic port, input logic [63:0] d);
      @(negedge clock_in);
      wr = 1'b1;
      sel_dp = port;
      sel_ss = ~port;
      wdata = d;
      @(negedge clock_in);
      wr = 1'b0;
   endtask : wr_reg

   task automatic final_report;
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report

   initial begin
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 367; i++) begin
            seed = lfsr(seed);
            img[i] = seed[0];
         end
         img[10:3] = 8'h01 << (seed[7:4] % 6);
         img[18:15] = 4'h1 << r;
         img[2] = img[1];
         rst_n_in = 1'b0;
         st_done = 1'b0;
         repeat (8) @(negedge clock_in);
         rst_n_in = 1'b1;
         repeat (4) @(negedge clock_in);
         cmp("early", '0, {done, shadow, ratio, thr, wide, fill});
         st_done = 1'b1;
         n = 0;
         hi = 0;
         while (done !== 1'b1 && n < 1000) begin
            @(negedge clock_in);
            n++;
            hi += (rom_clk === 1'b1);
         end
         if (n >= 1000) begin
            n_fail++;
            final_report();
         end
         cmp("boot_time", 1, n >= 734);
         cmp("rom_clocks", 367, hi);
         cmp("fields", {img[19:3], img[1:0]}, {shadow, ratio, fmt, busw,
             clean, thr, fill, wide});
      end
      exp_run = '0;
      for (int i = 0; i < 7; i++) begin
         seed = lfsr(seed);
         wr_reg(1'b1, {seed, lfsr(seed)});
         cmp("run_hold", exp_run, run_cfg);
         ret = 1'b1;
         @(negedge clock_in);
         ret = 1'b0;
         exp_run = {exp_run[29:0], wdata[5:0]};
         @(negedge clock_in);
         cmp("run_chain", exp_run, run_cfg);
      end
      seed = lfsr(seed);
      exp_err = {seed[27:0], lfsr(seed)};
      @(negedge clock_in);
      cap = 1'b1;
      err = exp_err;
      @(negedge clock_in);
      cap = 1'b0;
      wr_reg(1'b0, {seed, 32'h0});
      for (int i = 0; i < 11; i++) begin
         wr_reg(1'b0, {seed, 31'h0, 1'b1});
         rd = 1'b1;
         repeat (2) @(negedge clock_in);
         rd = 1'b0;
         cmp("err_port", {58'h0, exp_err[59:54]}, rdata);
         exp_err = {exp_err[53:0], 6'h0};
      end
      final_report();
   end
endmodule : tb_cucc_chains
